// ===== falm_regs.vh
// register map, field positions, reset values and timing counts of the filter entry matcher
// assumes inclusion by bare name from the matcher and the bench files
`ifndef FALM_REGS_VH
`define FALM_REGS_VH

// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define FALM_A_CFG0 8'h00
`define FALM_A_CFG1 8'h04
`define FALM_A_CFG2 8'h08
`define FALM_A_SRC_LO 8'h0C
`define FALM_A_SRC_HI 8'h10
`define FALM_A_DST_LO 8'h14
`define FALM_A_DST_HI 8'h18
`define FALM_A_HITS 8'h1C
`define FALM_A_STAT 8'h20
`define FALM_A_LOGS 8'h24

// ----------------------------------------
// cfg0 fields
// ----------------------------------------
`define FALM_C0_PORT_ANY 0
`define FALM_C0_POL_ANY 1
`define FALM_C0_FT_LSB 2
`define FALM_C0_DENY 5
`define FALM_C0_MIRROR 6
`define FALM_C0_LOG 7
`define FALM_C0_SHUT 8
`define FALM_C0_SRC_SPEC 9
`define FALM_C0_DM_LSB 10
`define FALM_C0_TAG_LSB 13
`define FALM_C0_VID_SPEC 15
`define FALM_C0_PRIO_ANY 16
`define FALM_C0_REDIR 17
`define FALM_C0_RATE 18
// reset: every filter Any, permit, all actions off
`define FALM_CFG0_RST 32'h0001_0003

// ----------------------------------------
// encodings
// ----------------------------------------
`define FALM_FT_ANY 3'h0
`define FALM_FT_ETH 3'h1
`define FALM_FT_ARP 3'h2
`define FALM_FT_IP4 3'h3
`define FALM_FT_IP6 3'h4
`define FALM_DM_ANY 3'h0
`define FALM_DM_GROUP 3'h1
`define FALM_DM_ALL 3'h2
`define FALM_DM_SINGLE 3'h3
`define FALM_DM_SPEC 3'h4
`define FALM_TAG_ANY 2'h0
`define FALM_TAG_YES 2'h1
`define FALM_TAG_NO 2'h2
`define FALM_ET_MIN 16'h0600
`define FALM_ET_ARP 16'h0806
`define FALM_ET_IP4 16'h0800
`define FALM_ET_IP6 16'h86DD
`define FALM_LEN_MAX 16'h05EE
`define FALM_RESP_OK 2'h0
`define FALM_RESP_ERR 2'h2
`define FALM_TICK_CYCLES 100000

`endif

// ===== falm_rate.v
// token bucket policer for frames that hit the filter entry
// assumes one hit pulse per frame and a configuration that changes rarely
`timescale 1ns/1ps
module falm_rate #(
  parameter TICK_CYCLES = 100000,
  parameter TW = 17
) (
  // clock and reset
  input wire i_clk,
  input wire i_rst_n,
  // configuration
  input wire i_en,
  input wire [3:0] i_units_m1,
  // per-frame
  input wire i_hit,
  output wire o_pass
);

  // ----------------------------------------
  // base-unit tick divider
  // ----------------------------------------
  reg [TW-1:0] tick_cnt_q;
  reg [4:0] tokens_q;
  reg [4:0] tokens_d;
  wire tick;
  wire [4:0] cap;

  assign tick = (tick_cnt_q == TICK_CYCLES[TW-1:0] - {{(TW-1){1'b0}}, 1'b1});
  assign cap = {1'b0, i_units_m1} + 5'h01;
  // disabled limiter never polices
  assign o_pass = !i_en || (tokens_q != 5'h00);

  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      tick_cnt_q <= {TW{1'b0}};
    end else if (tick) begin
      tick_cnt_q <= {TW{1'b0}};
    end else begin
      tick_cnt_q <= tick_cnt_q + {{(TW-1){1'b0}}, 1'b1};
    end
  end

  // ----------------------------------------
  // bucket: refill to the unit count each tick
  // ----------------------------------------
  always @* begin
    tokens_d = tokens_q;
    if (i_en && i_hit && tokens_q != 5'h00) begin
      tokens_d = tokens_q - 5'h01;
    end
    if (tick || !i_en) begin
      tokens_d = cap;
    end
  end

  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      tokens_q <= 5'h01;
    end else begin
      tokens_q <= tokens_d;
    end
  end

endmodule

// ===== falm_matcher.v
// single filter entry matcher with action outputs and an axi4-lite register slave
// assumes frame descriptors arrive one cycle each from logic on the same clock
//
// Design decisions made here: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "falm_regs.vh"
module falm_matcher #(
  parameter NUM_PORTS = 26,
  parameter TICK_CYCLES = `FALM_TICK_CYCLES
) (
  // clock and reset
  input wire I_MCLK,
  input wire I_RST_N,
  // axi4-lite write address
  input wire I_AWVALID,
  output reg O_AWREADY,
  input wire [7:0] I_AWADDR,
  // axi4-lite write data
  input wire I_WVALID,
  output reg O_WREADY,
  input wire [31:0] I_WDATA,
  input wire [3:0] I_WSTRB,
  // axi4-lite write response
  output reg O_BVALID,
  input wire I_BREADY,
  output reg [1:0] O_BRESP,
  // axi4-lite read
  input wire I_ARVALID,
  output reg O_ARREADY,
  input wire [7:0] I_ARADDR,
  output reg O_RVALID,
  input wire I_RREADY,
  output reg [31:0] O_RDATA,
  output reg [1:0] O_RRESP,
  // frame descriptor
  input wire I_FRM_VALID,
  input wire [7:0] I_FRM_PORT,
  input wire [7:0] I_FRM_POLICY,
  input wire [15:0] I_FRM_ETYPE,
  input wire [47:0] I_FRM_SRC,
  input wire [47:0] I_FRM_DST,
  input wire I_FRM_TAGGED,
  input wire [11:0] I_FRM_VID,
  input wire [2:0] I_FRM_PRIO,
  input wire [15:0] I_FRM_LEN,
  // verdict
  output reg O_RES_VALID,
  output reg O_HIT,
  output reg O_DROP,
  output reg O_REDIR,
  output reg [7:0] O_REDIR_PORT,
  output reg O_MIRROR,
  output reg O_LOG,
  output reg O_SHUT,
  output reg [7:0] O_SHUT_PORT
);

  // ----------------------------------------
  // configuration registers
  // ----------------------------------------
  reg [31:0] cfg0_q;
  reg [31:0] cfg1_q;
  reg [31:0] cfg2_q;
  reg [47:0] src_q;
  reg [47:0] dst_q;
  reg [31:0] hits_q;
  reg [31:0] logs_q;
  reg shut_seen_q;

  wire port_any = cfg0_q[`FALM_C0_PORT_ANY];
  wire pol_any = cfg0_q[`FALM_C0_POL_ANY];
  wire [2:0] ftype = cfg0_q[`FALM_C0_FT_LSB+2:`FALM_C0_FT_LSB];
  wire act_deny = cfg0_q[`FALM_C0_DENY];
  wire mirror_en = cfg0_q[`FALM_C0_MIRROR];
  wire log_en = cfg0_q[`FALM_C0_LOG];
  wire shut_en = cfg0_q[`FALM_C0_SHUT];
  wire src_spec = cfg0_q[`FALM_C0_SRC_SPEC];
  wire [2:0] dst_mode = cfg0_q[`FALM_C0_DM_LSB+2:`FALM_C0_DM_LSB];
  wire [1:0] tag_mode = cfg0_q[`FALM_C0_TAG_LSB+1:`FALM_C0_TAG_LSB];
  wire vid_spec = cfg0_q[`FALM_C0_VID_SPEC];
  wire prio_any = cfg0_q[`FALM_C0_PRIO_ANY];
  wire redir_en = cfg0_q[`FALM_C0_REDIR];
  wire rate_en = cfg0_q[`FALM_C0_RATE];
  wire [7:0] cfg_port = cfg1_q[7:0];
  wire [7:0] pol_val = cfg1_q[15:8];
  wire [7:0] pol_mask = cfg1_q[23:16];
  wire [2:0] cfg_prio = cfg1_q[26:24];
  wire [3:0] units_m1 = cfg1_q[31:28];
  wire [11:0] cfg_vid = cfg2_q[11:0];
  wire [7:0] redir_port = cfg2_q[23:16];

  // ----------------------------------------
  // frame classification
  // ----------------------------------------
  wire is_arp = (I_FRM_ETYPE == `FALM_ET_ARP);
  wire is_ip4 = (I_FRM_ETYPE == `FALM_ET_IP4);
  wire is_ip6 = (I_FRM_ETYPE == `FALM_ET_IP6);
  // plain ethertype excludes the three protocols carried elsewhere
  wire is_eth = (I_FRM_ETYPE >= `FALM_ET_MIN) && !is_arp && !is_ip4 && !is_ip6;
  wire dst_group = I_FRM_DST[40];
  wire dst_all = &I_FRM_DST;

  // ----------------------------------------
  // per-filter match terms
  // ----------------------------------------
  reg m_dst;
  wire m_type = (ftype == `FALM_FT_ANY) || (ftype == `FALM_FT_ETH && is_eth) ||
    (ftype == `FALM_FT_ARP && is_arp) || (ftype == `FALM_FT_IP4 && is_ip4) ||
    (ftype == `FALM_FT_IP6 && is_ip6);
  wire m_tag = (tag_mode == `FALM_TAG_ANY) || (tag_mode == `FALM_TAG_YES && I_FRM_TAGGED) ||
    (tag_mode == `FALM_TAG_NO && !I_FRM_TAGGED);
  wire m_port = port_any || (I_FRM_PORT == cfg_port);
  wire m_pol = pol_any || ((I_FRM_POLICY & pol_mask) == (pol_val & pol_mask));
  // source filter only exists for ethertype and arp entries
  wire src_live = src_spec && (ftype == `FALM_FT_ETH || ftype == `FALM_FT_ARP);
  wire m_src = !src_live || (I_FRM_SRC == src_q);
  // id 0 is not a legal setting, so it never matches a frame
  wire m_vid = !vid_spec || (I_FRM_TAGGED && cfg_vid != 12'h000 && I_FRM_VID == cfg_vid);
  wire m_prio = prio_any || (I_FRM_PRIO == cfg_prio);

  always @* begin
    case (dst_mode)
      `FALM_DM_ANY: m_dst = 1'b1;
      `FALM_DM_GROUP: m_dst = dst_group;
      `FALM_DM_ALL: m_dst = dst_all;
      `FALM_DM_SINGLE: m_dst = !dst_group;
      `FALM_DM_SPEC: m_dst = (I_FRM_DST == dst_q);
      default: m_dst = 1'b0;
    endcase
  end

  // ----------------------------------------
  // hit and actions
  // ----------------------------------------
  wire hit = I_FRM_VALID && m_port && m_pol && m_type && m_src && m_dst && m_tag && m_vid && m_prio;
  wire lim_pass;
  wire short_frm = (I_FRM_LEN < `FALM_LEN_MAX);
  // a denied frame is gone anyway, so it spends no token
  wire drop = hit && (act_deny || !lim_pass);
  wire port_ok = ({24'h000000, redir_port} < NUM_PORTS);

  falm_rate #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_rate (
    .i_clk(I_MCLK),
    .i_rst_n(I_RST_N),
    .i_en(rate_en),
    .i_units_m1(units_m1),
    .i_hit(hit && !act_deny),
    .o_pass(lim_pass)
  );

  always @(posedge I_MCLK) begin
    if (!I_RST_N) begin
      O_RES_VALID <= 1'b0;
      O_HIT <= 1'b0;
      O_DROP <= 1'b0;
      O_REDIR <= 1'b0;
      O_REDIR_PORT <= 8'h00;
      O_MIRROR <= 1'b0;
      O_LOG <= 1'b0;
      O_SHUT <= 1'b0;
      O_SHUT_PORT <= 8'h00;
    end else begin
      O_RES_VALID <= I_FRM_VALID;
      O_HIT <= hit;
      O_DROP <= drop;
      O_REDIR <= hit && !drop && redir_en && port_ok;
      O_REDIR_PORT <= redir_port;
      // the mirror copy ignores the limiter verdict
      O_MIRROR <= hit && mirror_en;
      O_LOG <= hit && log_en && short_frm;
      O_SHUT <= hit && shut_en && short_frm;
      O_SHUT_PORT <= I_FRM_PORT;
    end
  end

  // ----------------------------------------
  // axi4-lite write channel
  // ----------------------------------------
  reg aw_hold_q;
  reg w_hold_q;
  reg [7:0] aw_addr_q;
  reg [31:0] w_data_q;
  reg [3:0] w_strb_q;
  wire aw_take = I_AWVALID && O_AWREADY;
  wire w_take = I_WVALID && O_WREADY;
  wire do_wr = aw_hold_q && w_hold_q && !O_BVALID;
  wire aw_hold_d = aw_take || (aw_hold_q && !do_wr);
  wire w_hold_d = w_take || (w_hold_q && !do_wr);
  wire wr_ok = (aw_addr_q <= `FALM_A_LOGS) && (aw_addr_q[1:0] == 2'h0);
  wire hits_clr = do_wr && aw_addr_q == `FALM_A_HITS;
  wire logs_clr = do_wr && aw_addr_q == `FALM_A_LOGS;
  wire stat_clr = do_wr && aw_addr_q == `FALM_A_STAT && w_strb_q[0] && w_data_q[0];

  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] strb;
    integer k;
    begin
      for (k = 0; k < 4; k = k + 1) begin
        merge[k*8 +: 8] = strb[k] ? nw[k*8 +: 8] : old[k*8 +: 8];
      end
    end
  endfunction
  wire [31:0] src_hi_m = merge({16'h0000, src_q[47:32]}, w_data_q, w_strb_q);

  always @(posedge I_MCLK) begin
    if (!I_RST_N) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      O_AWREADY <= 1'b0;
      O_WREADY <= 1'b0;
      O_BVALID <= 1'b0;
      O_BRESP <= `FALM_RESP_OK;
    end else begin
      aw_hold_q <= aw_hold_d;
      w_hold_q <= w_hold_d;
      O_AWREADY <= !aw_hold_d;
      O_WREADY <= !w_hold_d;
      if (aw_take) begin
        aw_addr_q <= I_AWADDR;
      end
      if (w_take) begin
        w_data_q <= I_WDATA;
        w_strb_q <= I_WSTRB;
      end
      if (do_wr) begin
        O_BVALID <= 1'b1;
        O_BRESP <= wr_ok ? `FALM_RESP_OK : `FALM_RESP_ERR;
      end else if (I_BREADY) begin
        O_BVALID <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // register storage
  // ----------------------------------------
  always @(posedge I_MCLK) begin
    if (!I_RST_N) begin
      cfg0_q <= `FALM_CFG0_RST;
      cfg1_q <= 32'h0000_0000;
      cfg2_q <= 32'h0000_0000;
      src_q <= 48'h0000_0000_0000;
      dst_q <= 48'h0000_0000_0000;
    end else if (do_wr) begin
      if (aw_addr_q == `FALM_A_CFG0) begin
        cfg0_q <= merge(cfg0_q, w_data_q, w_strb_q);
      end else if (aw_addr_q == `FALM_A_CFG1) begin
        cfg1_q <= merge(cfg1_q, w_data_q, w_strb_q);
      end else if (aw_addr_q == `FALM_A_CFG2) begin
        cfg2_q <= merge(cfg2_q, w_data_q, w_strb_q);
      end else if (aw_addr_q == `FALM_A_SRC_LO) begin
        src_q[31:0] <= merge(src_q[31:0], w_data_q, w_strb_q);
      end else if (aw_addr_q == `FALM_A_SRC_HI) begin
        src_q[47:32] <= src_hi_m[15:0];
      end else if (aw_addr_q == `FALM_A_DST_LO) begin
        dst_q[31:0] <= merge(dst_q[31:0], w_data_q, w_strb_q);
      end else if (aw_addr_q == `FALM_A_DST_HI) begin
        dst_q[47:32] <= w_strb_q[1:0] == 2'h3 ? w_data_q[15:0] : dst_q[47:32];
      end
    end
  end

  // ----------------------------------------
  // counters and sticky status; a hit in a clear cycle restarts a counter at 1 and wins over the sticky clear
  // ----------------------------------------
  always @(posedge I_MCLK) begin
    if (!I_RST_N) begin
      hits_q <= 32'h0000_0000;
      logs_q <= 32'h0000_0000;
      shut_seen_q <= 1'b0;
    end else begin
      if (hit) begin
        hits_q <= hits_clr ? 32'h0000_0001 : hits_q + 32'h0000_0001;
      end else if (hits_clr) begin
        hits_q <= 32'h0000_0000;
      end
      if (hit && log_en && short_frm) begin
        logs_q <= logs_clr ? 32'h0000_0001 : logs_q + 32'h0000_0001;
      end else if (logs_clr) begin
        logs_q <= 32'h0000_0000;
      end
      if (hit && shut_en && short_frm) begin
        shut_seen_q <= 1'b1;
      end else if (stat_clr) begin
        shut_seen_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // axi4-lite read channel
  // ----------------------------------------
  reg [31:0] rd_mux;
  reg rd_ok;
  always @* begin
    rd_ok = 1'b1;
    rd_mux = 32'h0000_0000;
    if (I_ARADDR == `FALM_A_CFG0) begin
      rd_mux = cfg0_q;
    end else if (I_ARADDR == `FALM_A_CFG1) begin
      rd_mux = cfg1_q;
    end else if (I_ARADDR == `FALM_A_CFG2) begin
      rd_mux = cfg2_q;
    end else if (I_ARADDR == `FALM_A_SRC_LO) begin
      rd_mux = src_q[31:0];
    end else if (I_ARADDR == `FALM_A_SRC_HI) begin
      rd_mux = {16'h0000, src_q[47:32]};
    end else if (I_ARADDR == `FALM_A_DST_LO) begin
      rd_mux = dst_q[31:0];
    end else if (I_ARADDR == `FALM_A_DST_HI) begin
      rd_mux = {16'h0000, dst_q[47:32]};
    end else if (I_ARADDR == `FALM_A_HITS) begin
      rd_mux = hits_q;
    end else if (I_ARADDR == `FALM_A_STAT) begin
      rd_mux = {30'h0000_0000, lim_pass, shut_seen_q};
    end else if (I_ARADDR == `FALM_A_LOGS) begin
      rd_mux = logs_q;
    end else begin
      rd_ok = 1'b0;
    end
  end

  wire ar_take = I_ARVALID && O_ARREADY;
  wire rvalid_d = ar_take || (O_RVALID && !I_RREADY);

  always @(posedge I_MCLK) begin
    if (!I_RST_N) begin
      O_ARREADY <= 1'b0;
      O_RVALID <= 1'b0;
      O_RDATA <= 32'h0000_0000;
      O_RRESP <= `FALM_RESP_OK;
    end else begin
      O_RVALID <= rvalid_d;
      O_ARREADY <= !rvalid_d;
      if (ar_take) begin
        O_RDATA <= rd_mux;
        O_RRESP <= rd_ok ? `FALM_RESP_OK : `FALM_RESP_ERR;
      end
    end
  end

endmodule

// ===== falm_chk_assertions.sv
// verdict and bus hold checks for the filter entry matcher
// assumes one clock domain and the matcher's top-level port names
`timescale 1ns/1ps
module falm_chk #(
  parameter NUM_PORTS = 26
) (
  // clock, reset, frame in
  input wire I_MCLK,
  input wire I_RST_N,
  input wire I_FRM_VALID,
  input wire [7:0] I_FRM_PORT,
  input wire [15:0] I_FRM_LEN,
  // verdict
  input wire O_RES_VALID,
  input wire O_HIT,
  input wire O_DROP,
  input wire O_REDIR,
  input wire [7:0] O_REDIR_PORT,
  input wire O_MIRROR,
  input wire O_LOG,
  input wire O_SHUT,
  input wire [7:0] O_SHUT_PORT,
  // bus answers
  input wire O_BVALID,
  input wire I_BREADY,
  input wire O_RVALID,
  input wire I_RREADY,
  input wire [31:0] O_RDATA
);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (!I_RST_N);
  sequence s_hit;
    O_RES_VALID && O_HIT;
  endsequence
  sequence s_short;
    $past(I_FRM_LEN) < 16'h05EE;
  endsequence
  property p_res_lat;
    I_FRM_VALID |=> O_RES_VALID;
  endproperty
  a_res_lat: assert property (p_res_lat) else $error("verdict missing");
  property p_res_src;
    O_RES_VALID |-> $past(I_FRM_VALID);
  endproperty
  a_res_src: assert property (p_res_src) else $error("verdict without frame");
  property p_quiet;
    !O_RES_VALID |-> !(O_HIT || O_DROP || O_REDIR || O_MIRROR || O_LOG || O_SHUT);
  endproperty
  a_quiet: assert property (p_quiet) else $error("action outside verdict");
  property p_drop;
    O_DROP |-> s_hit;
  endproperty
  a_drop: assert property (p_drop) else $error("drop without hit");
  property p_mirror;
    O_MIRROR |-> s_hit;
  endproperty
  a_mirror: assert property (p_mirror) else $error("mirror without hit");
  property p_redir;
    O_REDIR |-> s_hit ##0 (!O_DROP && O_REDIR_PORT < NUM_PORTS);
  endproperty
  a_redir: assert property (p_redir) else $error("bad redirect");
  property p_log;
    O_LOG |-> s_hit ##0 s_short;
  endproperty
  a_log: assert property (p_log) else $error("bad log");
  property p_shut;
    O_SHUT |-> s_hit ##0 s_short ##0 (O_SHUT_PORT == $past(I_FRM_PORT));
  endproperty
  a_shut: assert property (p_shut) else $error("bad shutdown");
  property p_bhold;
    O_BVALID && !I_BREADY |=> O_BVALID;
  endproperty
  a_bhold: assert property (p_bhold) else $error("write answer dropped");
  property p_rhold;
    O_RVALID && !I_RREADY |=> O_RVALID && $stable(O_RDATA);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read answer dropped");
endmodule

bind falm_matcher falm_chk #(.NUM_PORTS(NUM_PORTS)) falm_chk_inst (
  .I_MCLK(I_MCLK), .I_RST_N(I_RST_N), .I_FRM_VALID(I_FRM_VALID),
  .I_FRM_PORT(I_FRM_PORT), .I_FRM_LEN(I_FRM_LEN), .O_RES_VALID(O_RES_VALID),
  .O_HIT(O_HIT), .O_DROP(O_DROP), .O_REDIR(O_REDIR), .O_REDIR_PORT(O_REDIR_PORT),
  .O_MIRROR(O_MIRROR), .O_LOG(O_LOG), .O_SHUT(O_SHUT), .O_SHUT_PORT(O_SHUT_PORT),
  .O_BVALID(O_BVALID), .I_BREADY(I_BREADY), .O_RVALID(O_RVALID),
  .I_RREADY(I_RREADY), .O_RDATA(O_RDATA));

// ===== falm_pipe_model.sv
// stand-in for the switch ingress pipeline: one descriptor per request cycle
// assumes the bench packs the fields and requests on the matcher clock
`timescale 1ns/1ps
module falm_pipe_model (
  // clock
  input wire i_clk,
  // request
  input wire i_go,
  input wire [159:0] i_frm,
  // descriptor
  output reg o_valid,
  output reg [159:0] o_frm
);
  // ----------------------------------------
  // issue
  // ----------------------------------------
  // fields invert between frames so stale values never look valid
  initial begin
    o_valid = 1'b0;
    o_frm = 160'h0;
  end
  always @(posedge i_clk) begin
    o_valid <= i_go;
    o_frm <= i_go ? i_frm : ~o_frm;
  end
endmodule

// ===== frame_access_list_matcher_tb_top.sv
// self-checking bench for the filter entry matcher
// assumes the matcher, its checker and the pipeline model are compiled first
`timescale 1ns/1ps
`include "falm_regs.vh"
module frame_access_list_matcher_tb_top;
  logic clk, rst_n, go, awv, wv, bry, arv, rry, awr, wrdy, bv, arr, rv;
  logic res, hit, drop, red, mir, lg, sh, ftag, pv;
  logic [7:0] awa, ara, rport, sport, rp, sp, fp, fpol;
  logic [1:0] bresp, rresp;
  logic [31:0] wd, rdat;
  logic [15:0] fet, flen;
  logic [47:0] fsrc, fdst;
  logic [11:0] fvid;
  logic [2:0] fpri;
  logic [159:0] pf;
  logic [5:0] v;
  logic [5:0] vq[$];
  logic [15:0] ets [6] = '{16'h0600, 16'h05FF, 16'h0806, 16'h0800, 16'h86DD, 16'hFFFF};
  logic [0:5] eth = 6'b100001;
  logic [47:0] dsts [3] = '{48'h0100_0000_0005, 48'hFFFF_FFFF_FFFF, 48'h0200_0000_0001};
  logic [0:11] dex = 12'b100_010_001_001;
  int err_total, checked, cyc, i, m, nd;
  // ----------------------------------------
  // design and far side
  // ----------------------------------------
  falm_pipe_model falm_pipe_model_inst (.i_clk(clk), .i_go(go),
    .i_frm({fp, fpol, fet, fsrc, fdst, ftag, fvid, fpri, flen}), .o_valid(pv), .o_frm(pf));
  falm_matcher #(.NUM_PORTS(26), .TICK_CYCLES(20)) falm_matcher_inst (
    .I_MCLK(clk), .I_RST_N(rst_n), .I_AWVALID(awv), .O_AWREADY(awr), .I_AWADDR(awa),
    .I_WVALID(wv), .O_WREADY(wrdy), .I_WDATA(wd), .I_WSTRB(4'hF), .O_BVALID(bv),
    .I_BREADY(bry), .O_BRESP(bresp), .I_ARVALID(arv), .O_ARREADY(arr), .I_ARADDR(ara),
    .O_RVALID(rv), .I_RREADY(rry), .O_RDATA(rdat), .O_RRESP(rresp), .I_FRM_VALID(pv),
    .I_FRM_PORT(pf[159:152]), .I_FRM_POLICY(pf[151:144]), .I_FRM_ETYPE(pf[143:128]),
    .I_FRM_SRC(pf[127:80]), .I_FRM_DST(pf[79:32]), .I_FRM_TAGGED(pf[31]),
    .I_FRM_VID(pf[30:19]), .I_FRM_PRIO(pf[18:16]), .I_FRM_LEN(pf[15:0]),
    .O_RES_VALID(res), .O_HIT(hit), .O_DROP(drop), .O_REDIR(red), .O_REDIR_PORT(rport),
    .O_MIRROR(mir), .O_LOG(lg), .O_SHUT(sh), .O_SHUT_PORT(sport));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task chk(input logic [39:0] s, input logic [39:0] e);
    checked++;
    if (s !== e) begin
      err_total++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, s, e);
    end
  endtask
  task end_sim();
    $display("checks %0d, mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  function automatic logic [5:0] pop();
    if (vq.size() == 0) return 6'bx;
    return vq.pop_front();
  endfunction
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = `FALM_RESP_OK);
    @(posedge clk);
    awv <= 1'b1;
    wv <= 1'b1;
    awa <= a;
    wd <= d;
    bry <= 1'b1;
    do begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wrdy) wv <= 1'b0;
    end while (bv !== 1'b1);
    bry <= 1'b0;
    chk({bv, bresp}, {1'b1, r});
  endtask
  task rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = `FALM_RESP_OK);
    @(posedge clk);
    arv <= 1'b1;
    ara <= a;
    rry <= 1'b1;
    do begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
    end while (rv !== 1'b1);
    rry <= 1'b0;
    chk({rv, rresp, rdat}, {1'b1, r, d});
  endtask
  // results are queued so back-to-back frames can be judged afterwards
  task send(input int n);
    @(posedge clk);
    go <= 1'b1;
    repeat (n) @(posedge clk);
    go <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task tv(input logic [5:0] e);
    send(1);
    chk(pop(), e);
  endtask
  always @(posedge clk) begin
    if (res === 1'b1) begin
      vq.push_back({hit, drop, mir, red, lg, sh});
      rp = rport;
      sp = sport;
    end
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      end_sim();
    end
  end
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    {rst_n, go, awv, wv, bry, arv, rry, awa, ara, wd} = '0;
    {fp, fpol, fet, flen} = {8'h05, 8'hA3, 16'h0600, 16'h0040};
    {fsrc, fdst} = {48'h8000_1122_3344, 48'h0200_0000_0001};
    {ftag, fvid, fpri} = {1'b1, 12'h064, 3'h3};
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    rd(`FALM_A_CFG0, 32'h0001_0003);
    rd(8'h28, 32'h0, `FALM_RESP_ERR);
    wr(8'h28, 32'h1, `FALM_RESP_ERR);
    tv(6'h20);
    wr(`FALM_A_CFG1, 32'h03F0_A505);
    wr(`FALM_A_CFG0, 32'h0);
    tv(6'h20);
    fp <= 8'h06;
    tv(6'h00);
    fp <= 8'h05;
    fpol <= 8'h53;
    tv(6'h00);
    fpol <= 8'hA3;
    fpri <= 3'h2;
    tv(6'h00);
    fpri <= 3'h3;
    wr(`FALM_A_CFG0, 32'h0001_0007);
    for (i = 0; i < 6; i++) begin
      fet <= ets[i];
      tv({eth[i], 5'h0});
    end
    for (i = 2; i < 5; i++) begin
      wr(`FALM_A_CFG0, 32'h0001_0003 | (i << 2));
      fet <= ets[i];
      tv(6'h20);
    end
    wr(`FALM_A_SRC_LO, 32'h1122_3344);
    wr(`FALM_A_SRC_HI, 32'h0000_8000);
    wr(`FALM_A_CFG0, 32'h0001_0203);
    fsrc <= 48'h0000_1122_3344;
    tv(6'h20);
    wr(`FALM_A_CFG0, 32'h0001_0207);
    fet <= 16'h0600;
    tv(6'h00);
    fsrc <= 48'h8000_1122_3344;
    tv(6'h20);
    wr(`FALM_A_DST_LO, 32'h0000_0001);
    wr(`FALM_A_DST_HI, 32'h0000_0200);
    for (m = 1; m < 5; m++) begin
      wr(`FALM_A_CFG0, 32'h0001_0003 | (m << 10));
      for (i = 0; i < 3; i++) begin
        if (m != 1 || i != 1) begin
          fdst <= dsts[i];
          tv({dex[(m - 1) * 3 + i], 5'h0});
        end
      end
    end
    wr(`FALM_A_CFG0, 32'h0001_2003);
    tv(6'h20);
    ftag <= 1'b0;
    tv(6'h00);
    wr(`FALM_A_CFG0, 32'h0001_4003);
    tv(6'h20);
    ftag <= 1'b1;
    tv(6'h00);
    wr(`FALM_A_CFG2, 32'h0007_0064);
    wr(`FALM_A_CFG0, 32'h0001_8003);
    tv(6'h20);
    fvid <= 12'h065;
    tv(6'h00);
    fvid <= 12'h064;
    wr(`FALM_A_HITS, 32'h0);
    wr(`FALM_A_LOGS, 32'h0);
    wr(`FALM_A_CFG0, 32'h0003_01C3);
    flen <= 16'h05ED;
    tv(6'h2F);
    chk(rp, 8'h07);
    chk(sp, 8'h05);
    flen <= 16'h05EE;
    tv(6'h2C);
    wr(`FALM_A_CFG0, 32'h0003_01E3);
    tv(6'h38);
    rd(`FALM_A_HITS, 32'h3);
    rd(`FALM_A_LOGS, 32'h1);
    rd(`FALM_A_STAT, 32'h3);
    wr(`FALM_A_STAT, 32'h1);
    rd(`FALM_A_STAT, 32'h2);
    wr(`FALM_A_CFG2, 32'h001A_0064);
    wr(`FALM_A_CFG0, 32'h0002_0003);
    tv(6'h20);
    // one token per tick: of four back-to-back hits at most one refill lands
    wr(`FALM_A_CFG0, 32'h0005_0043);
    repeat (25) @(posedge clk);
    send(4);
    nd = 0;
    for (i = 0; i < 4; i++) begin
      v = pop();
      chk(v | 6'h10, 6'h38);
      nd += v[4];
    end
    chk(nd == 2 || nd == 3, 1'b1);
    end_sim();
  end
endmodule
